/* design/acr_pkg.sv */
// constants, types and helpers shared by both ends of the control-word link
// assumes one 100 MHz clock that also serves as the internal conversion clock
// What the document asks of this block and of the host
// R1: writes are address word, then data word
// R2: control at address 0x0001, resets to 0x001A
// R3: arm bit turns later writes into coefficients
// R4: host sets tap count with arm bit
// R5: coefficients go upper word first, centre outward
// R6: checksum is byte sum, compared inside
// R7: zero unused slots, half clock each
// R8: host reads status, checks match bit
// R9: bit 14 selects threshold on next read
// R10: bit 13 selects gain on next read
// R11: bit 12 selects offset on next read
// R12: bit 11 selects status on next read
// R13: host always writes zero to bit 10
// R14: bit 9 starts filter alignment routine
// R15: bits 15 to 9 clear themselves
// R16: bit 4 zero bypasses the fir stage
// R17: bit 3 zero bypasses first stage
// R18: bits 2-0 select decimation two to n
// R19: host keeps tap and decimation on selects
// R20: host scales half coefficient set sum
// R21: upper word: five zeros, sign, magnitude high
// R22: match flag only when checksums agree
// R23: host sets at most one select bit
// R24: no pending select returns conversion data
package acr_pkg;
  localparam logic [15:0] CTRL_ADDR = 16'h0001; // control register address
  localparam logic [8:0] CTRL_RESET = 9'h01A; // stored low bits after reset
  localparam int B_ARM = 15; // coefficient load arm
  localparam int B_RD_THR = 14; // threshold read select
  localparam int B_RD_GAIN = 13; // gain read select
  localparam int B_RD_OFF = 12; // offset read select
  localparam int B_RD_STAT = 11; // status read select
  localparam int B_ZERO = 10; // must be written as zero
  localparam int B_ALIGN = 9; // filter alignment start
  localparam int B_TAP_HI = 8; // tap_count_code msb
  localparam int B_TAP_LO = 5; // tap_count_code lsb
  localparam int B_FIR_KEEP = 4; // fir_stage_keep
  localparam int B_FIRST_KEEP = 3; // first_stage_keep
  localparam int B_STAT_MATCH = 7; // load_checksum_match in status word
  localparam int NCOEF_MAX = 48; // coefficient slots
  localparam logic [1:0] PART_CODE = 2'h1; // arbitrary value
  // zero fill: half an internal clock period per slot
  localparam int CLK_PERIOD_NS = 10;
  localparam int INTERNAL_CLOCK_PERIOD_NS = 10;
  localparam int FILL_SLOT_PS = 500 * INTERNAL_CLOCK_PERIOD_NS; // 0.5 internal periods
  localparam int FILL_SLOTS_PER_CLK = (CLK_PERIOD_NS * 1000) / FILL_SLOT_PS;
  // host apb map
  localparam logic [11:0] H_TX_OFF = 12'h000; // write: send one bus word
  localparam logic [11:0] H_RX_OFF = 12'h004; // read: one bus read cycle
  localparam logic [11:0] H_STAT_OFF = 12'h008; // bit0 device busy
  // read select encoding
  typedef enum logic [1:0] {
    SEL_THR = 2'h0, SEL_GAIN = 2'h1, SEL_OFF = 2'h2, SEL_STAT = 2'h3
  } acr_sel_t;
  // number of downloaded coefficients for a tap code
  function automatic logic [5:0] acr_ncoef(input logic [3:0] c);
    logic [5:0] k;
    k = {3'b000, c[3:1]} + 6'h01;
    return (k << 2) + (k << 1);
  endfunction
endpackage

/* design/acr_link_if.sv */
// the 16-bit parallel link between host and device ends
// assumes both ends run on the same sys_clk
`timescale 1ns/100ps
interface acr_link_if;
  logic wr_stb; // one-cycle write strobe
  logic [15:0] wr_data; // word written
  logic rd_stb; // one-cycle read request
  logic [15:0] rd_data; // word read back
  logic rd_ack; // one-cycle read answer
  logic busy; // device filling unused slots
  modport dev (input wr_stb, wr_data, rd_stb, output rd_data, rd_ack, busy);
  modport host (output wr_stb, wr_data, rd_stb, input rd_data, rd_ack, busy);
endinterface

/* design/acr_dev_end.sv */
// device end: control register, read select and coefficient loader
// assumes host strobes are synchronous to sys_clk and one cycle wide
// and that no word is sent while busy is high: such a word is dropped
`timescale 1ns/100ps
module acr_dev_end import acr_pkg::*; (
  input wire logic sys_clk,
  input wire logic srst,
  acr_link_if.dev link,
  input wire logic [15:0] conv_data,
  input wire logic [15:0] gain_value,
  input wire logic [15:0] offset_value,
  input wire logic [15:0] thresh_value,
  input wire logic [2:0] die_id,
  input wire logic data_valid,
  input wire logic low_power,
  input wire logic over_range,
  input wire logic filter_ok,
  input wire logic [5:0] coef_rd_idx,
  output logic [26:0] coef_rd_data,
  output logic fir_stage_keep,
  output logic first_stage_keep,
  output logic [2:0] decim_code,
  output logic [3:0] tap_count_code,
  output logic align_start,
  output logic load_checksum_match,
  output logic user_filter
);
  // link states, one-hot: address word, data word, coefficient words, zero fill
  typedef enum logic [3:0] {
    ST_ADDR = 4'b0001, ST_DATA = 4'b0010, ST_COEF = 4'b0100, ST_FILL = 4'b1000
  } acr_dst_t;

  // state of the link and of the download
  acr_dst_t st_q, st_d; // link state
  logic [15:0] addr_q; // address word of the pending write
  logic [8:0] ctrl_q; // stored control bits, upper bits never held
  logic align_q; // one-cycle alignment start
  logic sel_vld_q; // a register read is pending
  acr_sel_t sel_q; // which register the next read returns
  logic [5:0] ncoef_q; // coefficients in this download
  logic [6:0] wcnt_q; // coefficient words taken so far
  logic [10:0] hi_q; // held upper word of a coefficient
  logic [15:0] sum_q; // running byte sum
  logic [5:0] fill_q; // next slot to zero
  logic match_q; // checksums agreed
  logic user_q; // user coefficients loaded
  logic busy_q; // filling in progress
  logic [15:0] rd_data_q; // read answer
  logic rd_ack_q; // read answer strobe
  logic [26:0] coef_q [NCOEF_MAX]; // coefficient slots
  logic [26:0] coef_rd_q; // coefficient read port

  // decode of the incoming word
  wire wr = link.wr_stb;
  wire [15:0] wd = link.wr_data;
  // a data word reaches the control register only behind its own address word
  wire ctrl_wr = wr && st_q == ST_DATA && addr_q == CTRL_ADDR; // [R1] [R2]
  // tap code zero means no download, so the word is an ordinary control write
  wire arm = ctrl_wr && wd[B_ARM] && wd[B_TAP_HI:B_TAP_LO] != 4'h0; // [R3]
  wire [6:0] nwords = {ncoef_q, 1'b0}; // two words per coefficient [R5]
  // the word after the last coefficient is taken as the checksum
  wire coef_wr = wr && st_q == ST_COEF && wcnt_q != nwords;
  wire csum_wr = wr && st_q == ST_COEF && wcnt_q == nwords; // [R6]
  // each word adds both of its bytes; the sum wraps at 16 bits
  wire [15:0] byte_sum = {8'h00, wd[15:8]} + {8'h00, wd[7:0]}; // [R6]
  // a pair of words fills one slot, so the slot is the word count halved
  wire [5:0] slot = wcnt_q[6:1];
  // two slots per clock: a slot takes half an internal clock, which is sys_clk
  wire fill_done = fill_q >= 6'(NCOEF_MAX);
  wire [5:0] fill_next = 6'(fill_q + 6'(FILL_SLOTS_PER_CLK)); // [R7]
  // first select bit wins if the host sets several, highest first
  wire sel_set = ctrl_wr && (|wd[B_RD_THR:B_RD_STAT]);
  wire acr_sel_t sel_new = acr_sel_t'(wd[B_RD_THR] ? SEL_THR : wd[B_RD_GAIN] ? SEL_GAIN :
                           wd[B_RD_OFF] ? SEL_OFF : SEL_STAT);
  // status as read back; the keep bits read inverted, as bypass flags
  wire [15:0] status_word = {PART_CODE, die_id, data_valid, low_power, over_range,
                             match_q, filter_ok, user_q, ~ctrl_q[B_FIR_KEEP],
                             ~ctrl_q[B_FIRST_KEEP], ctrl_q[2:0]};
  wire [15:0] sel_word = sel_q == SEL_THR ? thresh_value : // [R9]
                         sel_q == SEL_GAIN ? gain_value : // [R10]
                         sel_q == SEL_OFF ? offset_value : status_word; // [R11] [R12]

  // next state of the link
  always_comb begin
    st_d = st_q;
    // a download cut short waits in ST_COEF for more words; only reset ends it
    case (st_q)
      ST_ADDR: if (wr) st_d = ST_DATA; // address word first [R1]
      ST_DATA: if (wr) st_d = arm ? ST_COEF : ST_ADDR;
      ST_COEF: if (csum_wr) st_d = ST_FILL; // checksum ends the words [R3]
      ST_FILL: if (fill_done) st_d = ST_ADDR;
      default: st_d = ST_ADDR;
    endcase
  end

  // state, address and busy flag
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= ST_ADDR;
      addr_q <= 16'h0000;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (wr && st_q == ST_ADDR) addr_q <= wd;
      // busy follows the next state, so it rises on the checksum edge itself
      busy_q <= st_d == ST_FILL; // host holds off while zeros go in [R7]
    end
  end

  // control register; the action bits are not stored so they self-clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RESET; // [R2]
      align_q <= 1'b0;
    end else begin
      // the action bits work only on the write that carries them; bit 10 is dropped
      align_q <= ctrl_wr && wd[B_ALIGN]; // one pulse, then gone [R14] [R15]
      // the low bits hold until the next control write
      if (ctrl_wr) ctrl_q <= wd[8:0]; // [R16] [R17] [R18]
    end
  end

  // read select; a new select wins over the read that consumes the old one
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sel_vld_q <= 1'b0;
      sel_q <= SEL_STAT;
      rd_data_q <= 16'h0000;
      rd_ack_q <= 1'b0;
    end else begin
      // the answer comes exactly one cycle after the strobe
      rd_ack_q <= link.rd_stb;
      // sources are sampled on the strobe edge; later changes wait for the next read
      if (link.rd_stb) rd_data_q <= sel_vld_q ? sel_word : conv_data; // [R24]
      if (sel_set) begin
        sel_vld_q <= 1'b1; // armed for the next read [R9] [R10] [R11] [R12]
        sel_q <= sel_new;
      end else if (link.rd_stb) begin
        sel_vld_q <= 1'b0; // served once, back to conversion data [R24] [R15]
      end
    end
  end

  // download counters and checksum
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ncoef_q <= 6'h00;
      wcnt_q <= 7'h00;
      hi_q <= 11'h000;
      sum_q <= 16'h0000;
      fill_q <= 6'h00;
      match_q <= 1'b0;
      user_q <= 1'b0;
    end else if (arm) begin
      // even tap codes load as many coefficients as the odd code above them
      ncoef_q <= acr_ncoef(wd[B_TAP_HI:B_TAP_LO]); // tap count taken now [R4]
      wcnt_q <= 7'h00;
      sum_q <= 16'h0000;
      match_q <= 1'b0; // old result no longer stands
    end else if (coef_wr) begin
      wcnt_q <= 7'(wcnt_q + 7'h01);
      sum_q <= 16'(sum_q + byte_sum); // [R6]
      // bits 15 to 11 of the upper word are padding and are not kept
      if (!wcnt_q[0]) hi_q <= wd[10:0]; // upper word: sign and mag 25:16 [R21]
    end else if (csum_wr) begin
      match_q <= sum_q == wd; // [R22]
      // user_filter is set by the checksum word whether or not the sums agree
      user_q <= 1'b1;
      fill_q <= ncoef_q;
    end else if (st_q == ST_FILL && !fill_done) begin
      fill_q <= fill_next; // [R7]
    end
  end

  // coefficient slots, cleared by reset; two zeros per clock when filling
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < NCOEF_MAX; i++) coef_q[i] <= 27'h000_0000;
    end else if (coef_wr && wcnt_q[0]) begin
      // no word arrives while filling, so the two branches never meet
      coef_q[slot] <= {hi_q, wd}; // lower word completes it, centre first [R5] [R21]
    end else if (st_q == ST_FILL && !fill_done) begin
      // the fill starts at an even slot, so both slots stay below 48
      coef_q[fill_q] <= 27'h000_0000; // [R7]
      coef_q[6'(fill_q + 6'h01)] <= 27'h000_0000;
    end
  end

  // coefficient read port for the filter datapath
  always_ff @(posedge sys_clk) begin
    if (srst) coef_rd_q <= 27'h000_0000;
    // an index past the last slot reads zero instead of wrapping
    else coef_rd_q <= coef_rd_idx < 6'(NCOEF_MAX) ? coef_q[coef_rd_idx] : 27'h000_0000;
  end

  // every output comes straight from a register
  assign link.rd_data = rd_data_q;
  assign link.rd_ack = rd_ack_q;
  assign link.busy = busy_q;
  assign coef_rd_data = coef_rd_q;
  assign fir_stage_keep = ctrl_q[B_FIR_KEEP]; // [R16]
  assign first_stage_keep = ctrl_q[B_FIRST_KEEP]; // [R17]
  assign decim_code = ctrl_q[2:0]; // [R18]
  assign tap_count_code = ctrl_q[B_TAP_HI:B_TAP_LO];
  assign align_start = align_q; // [R14]
  assign load_checksum_match = match_q;
  assign user_filter = user_q;
endmodule // acr_dev_end

/* design/acr_host_end.sv */
// host end: apb slave that turns register accesses into link words
// assumes software sequences address, data, coefficient and checksum words
`timescale 1ns/100ps
module acr_host_end import acr_pkg::*; (
  input wire logic sys_clk,
  input wire logic srst,
  acr_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [1:0] {HS_IDLE = 2'b01, HS_READ = 2'b10} acr_hst_t;

  acr_hst_t st_q; // access state
  logic wr_stb_q; // link write strobe
  logic [15:0] wr_data_q; // link write word
  logic rd_stb_q; // link read strobe
  logic [31:0] prdata_q; // apb read data
  logic pready_q; // apb ready, one cycle
  logic pslverr_q; // apb error

  // decode of the access phase
  wire acc = psel && penable && !pready_q;
  wire a_tx = paddr == H_TX_OFF;
  wire a_rx = paddr == H_RX_OFF;
  wire a_st = paddr == H_STAT_OFF;
  // a word may not go while the device zeros slots [R7]
  wire tx_go = acc && a_tx && pwrite && !link.busy;
  wire rx_go = acc && a_rx && !pwrite;
  wire other = acc && !(a_tx && pwrite) && !(a_rx && !pwrite) && !(a_st && !pwrite);

  // access sequencer; a read stalls apb until the device answers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= HS_IDLE;
      wr_stb_q <= 1'b0;
      wr_data_q <= 16'h0000;
      rd_stb_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      case (st_q)
        HS_IDLE: begin
          if (tx_go) begin
            wr_stb_q <= 1'b1; // one word per access, address then data [R1]
            wr_data_q <= pwdata[15:0]; // software keeps bit 10 zero [R13] [R19] [R23]
            pready_q <= 1'b1;
          end else if (rx_go) begin
            rd_stb_q <= 1'b1; // status read after a download [R8]
            st_q <= HS_READ;
          end else if (acc && a_st && !pwrite) begin
            prdata_q <= {31'h0000_0000, link.busy};
            pready_q <= 1'b1;
          end else if (other) begin
            pready_q <= 1'b1; // unmapped or wrong direction
            pslverr_q <= 1'b1;
          end
        end
        HS_READ: begin
          if (link.rd_ack) begin
            prdata_q <= {16'h0000, link.rd_data};
            pready_q <= 1'b1;
            st_q <= HS_IDLE;
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  assign link.wr_stb = wr_stb_q;
  assign link.wr_data = wr_data_q;
  assign link.rd_stb = rd_stb_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule // acr_host_end

/* sim/acr_link_monitor.sv */
// link checker: watches the word link between host end and device end
// assumes both ends share sys_clk and srst is synchronous, active high
`timescale 1ns/100ps
module acr_link_monitor (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wr_stb,
  input wire logic [15:0] wr_data,
  input wire logic rd_stb,
  input wire logic [15:0] rd_data,
  input wire logic rd_ack,
  input wire logic busy
);
  logic [1:0] ph_q; // 0 address, 1 data, 2 coefficient words
  logic ctl_q; // last address word named the control register
  logic [6:0] left_q; // words still due, checksum included
  logic [5:0] fill_q; // busy length expected after the checksum
  logic ck_q; // checksum word taken on the last edge
  logic [5:0] bcnt_q; // busy cycles counted so far
  wire [5:0] ncoef = ({3'b000, wr_data[8:6]} + 6'h01) * 6'h06; // odd codes round down
  wire arm = ctl_q && wr_data[15] && (wr_data[8:5] != 4'h0);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // shadow of the word order; writes during busy are dropped, as the device does
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ph_q <= 2'h0;
      ck_q <= 1'b0;
    end else begin
      ck_q <= 1'b0;
      if (wr_stb && !busy && ph_q == 2'h0) begin
        ph_q <= 2'h1;
        ctl_q <= (wr_data == 16'h0001);
      end else if (wr_stb && !busy && ph_q == 2'h1) begin
        ph_q <= arm ? 2'h2 : 2'h0;
        left_q <= {ncoef, 1'b0} + 7'h01;
        fill_q <= ((6'h30 - ncoef) >> 1) + 6'h01;
      end else if (wr_stb && !busy) begin
        left_q <= left_q - 7'h01;
        ph_q <= (left_q == 7'h01) ? 2'h0 : 2'h2;
        ck_q <= (left_q == 7'h01);
      end
    end
  end
  // busy run length, cleared whenever busy is low
  always_ff @(posedge sys_clk) begin
    if (srst) bcnt_q <= 6'h00;
    else bcnt_q <= busy ? bcnt_q + 6'h01 : 6'h00;
  end
  chk_ack_after_read: assert property (rd_stb |=> rd_ack)
    else $error("read strobe not answered next cycle");
  chk_ack_has_cause: assert property (rd_ack |-> $past(rd_stb))
    else $error("read answer without a read strobe");
  chk_ack_one_cycle: assert property (rd_ack |=> !rd_ack)
    else $error("read answer longer than one cycle");
  chk_read_word_hold: assert property (!rd_ack |-> $stable(rd_data))
    else $error("read word changed without an answer");
  chk_write_one_cycle: assert property (wr_stb |=> !wr_stb)
    else $error("write strobe longer than one cycle");
  chk_busy_from_cksum: assert property ($rose(busy) |-> ck_q)
    else $error("busy rose without a checksum word");
  chk_cksum_starts_fill: assert property (ck_q |-> busy)
    else $error("checksum word did not start the zero fill");
  chk_fill_length: assert property ($fell(busy) |-> bcnt_q == fill_q)
    else $error("zero fill length wrong");
  chk_no_write_busy: assert property (busy |-> !wr_stb)
    else $error("word sent while zero fill runs");
endmodule // acr_link_monitor

/* sim/test_adc_ctrl_reg_and_coef_loader.sv */
// testbench: apb host end joined to device end, self-checking
// assumes a 100 MHz sys_clk and the host map of the package
`timescale 1ns/100ps
module test_adc_ctrl_reg_and_coef_loader import acr_pkg::*;;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rr;
  logic pready, pslverr, ee;
  logic [15:0] conv_data = 16'h4321, gain_value = 16'hA000;
  logic [15:0] offset_value = 16'h0000, thresh_value = 16'hCCCC;
  logic [2:0] die_id = 3'h5;
  logic data_valid = 1'b1, low_power = 1'b0, over_range = 1'b1, filter_ok = 1'b0;
  logic [5:0] coef_rd_idx = 6'h00;
  logic [26:0] coef_rd_data;
  logic fir_stage_keep, first_stage_keep, align_start, load_checksum_match, user_filter;
  logic [2:0] decim_code;
  logic [3:0] tap_count_code;
  int n_fail = 0;
  int total_checks = 0;
  int al_cnt = 0; // alignment pulses seen
  // the 24-tap example, upper word then lower word per coefficient
  logic [15:0] cw [24] = '{16'h032B, 16'h9688, 16'h01BF, 16'h183C, 16'h0015, 16'h6626,
    16'h04A8, 16'h1E6A, 16'h045F, 16'h2A96, 16'h002C, 16'h49C2, 16'h0050, 16'hE9F6,
    16'h0010, 16'hDBD8, 16'h042F, 16'hDE54, 16'h0437, 16'h445A, 16'h041B, 16'h7D6E,
    16'h0404, 16'h3B5F};
  acr_link_if link();
  acr_dev_end i_acr_dev_end (.sys_clk, .srst, .link(link), .conv_data, .gain_value,
    .offset_value, .thresh_value, .die_id, .data_valid, .low_power, .over_range,
    .filter_ok, .coef_rd_idx, .coef_rd_data, .fir_stage_keep, .first_stage_keep,
    .decim_code, .tap_count_code, .align_start, .load_checksum_match, .user_filter);
  acr_host_end i_acr_host_end (.sys_clk, .srst, .link(link), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr);
  acr_link_monitor i_acr_link_monitor (.sys_clk, .srst, .wr_stb(link.wr_stb),
    .wr_data(link.wr_data), .rd_stb(link.rd_stb), .rd_data(link.rd_data),
    .rd_ack(link.rd_ack), .busy(link.busy));
  always #5 sys_clk = ~sys_clk;
  // count alignment pulses; more than one means the bit did not clear
  always @(posedge sys_clk) if (align_start === 1'b1) al_cnt++;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; waits on pready, bounded so a hang cannot stall the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) n_fail++;
    rr = prdata;
    ee = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic lw(input logic [15:0] w);
    apb(1'b1, H_TX_OFF, {16'h0000, w});
  endtask
  // control write, then two edges so the device has taken the word
  task automatic wctl(input logic [15:0] d);
    lw(16'h0001);
    lw(d);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic peek(input logic [5:0] i, input logic [26:0] x);
    @(posedge sys_clk);
    coef_rd_idx <= i;
    repeat (2) @(posedge sys_clk);
    check("coef slot", {5'h00, coef_rd_data}, {5'h00, x});
  endtask
  function automatic logic [15:0] stat(input logic m, input logic u, input logic [4:0] c);
    return {PART_CODE, die_id, data_valid, low_power, over_range, m, filter_ok, u, ~c[4],
      ~c[3], c[2:0]};
  endfunction
  function automatic logic [15:0] csum(input int n);
    logic [15:0] s = 16'h0000;
    for (int i = 0; i < n; i++) s += 16'(cw[i][15:8]) + 16'(cw[i][7:0]);
    return s;
  endfunction
  // download, then poll the busy flag until the zero fill is over
  task automatic load(input logic [15:0] ctl, input int nw, input logic [15:0] ck);
    int k = 0;
    wctl(ctl); // arm and tap count in one word, bit 10 zero
    for (int i = 0; i < nw; i++) lw(cw[i]);
    lw(ck);
    apb(1'b0, H_STAT_OFF, 32'h0000_0000);
    check("busy after checksum", rr[0], 1'b1);
    while (rr[0] !== 1'b0 && k++ < 40) apb(1'b0, H_STAT_OFF, 32'h0000_0000);
    check("busy cleared", rr[0], 1'b0);
  endtask
  task automatic t_reset();
    check("keep flags", {fir_stage_keep, first_stage_keep}, 2'b11);
    check("decim and taps", {decim_code, tap_count_code}, 7'h20);
    check("match and user", {load_checksum_match, user_filter}, 2'b00);
    $display("test reset done");
  endtask
  task automatic t_ctrl();
    wctl(16'h021A);
    check("align pulses", al_cnt, 1);
    lw(16'h0002);
    lw(16'hFFFF);
    repeat (2) @(posedge sys_clk);
    check("decim after other address", decim_code, 3'h2);
    wctl(16'h8013); // arm with tap code zero is a plain write
    check("decim after arm without taps", decim_code, 3'h3);
    wctl(16'h001A);
    check("decim after next control write", decim_code, 3'h2);
    apb(1'b0, H_RX_OFF, 32'h0000_0000);
    check("plain read", rr[15:0], conv_data);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check("unmapped error", ee, 1'b1);
    $display("test control done");
  endtask
  // every select bit and decimation codes 0 to 5; each read reverts afterwards
  task automatic t_select();
    logic [15:0] d, x;
    for (int k = 0; k < 6; k++) begin
      d = (16'h4000 >> (k % 4)) | {11'h000, k[0], k[1], k[2:0]};
      thresh_value <= 16'h1000 + 16'(k);
      gain_value <= 16'h2000 + 16'(k);
      offset_value <= 16'h3000 + 16'(k);
      conv_data <= 16'h4000 + 16'(k);
      {die_id, data_valid, low_power, over_range, filter_ok} <= {k[2:0], k[0], k[1], k[2], ~k[0]};
      wctl(d); // one select bit, bit 10 zero
      check("decim code", decim_code, k[2:0]);
      check("stage keeps", {fir_stage_keep, first_stage_keep}, {k[0], k[1]});
      x = (k % 4 == 0) ? thresh_value : (k % 4 == 1) ? gain_value :
        (k % 4 == 2) ? offset_value : stat(1'b0, 1'b0, d[4:0]);
      apb(1'b0, H_RX_OFF, 32'h0000_0000);
      check("selected read", rr[15:0], x);
      apb(1'b0, H_RX_OFF, 32'h0000_0000);
      check("read after select", rr[15:0], conv_data);
    end
    $display("test select done");
  endtask
  task automatic t_load_good();
    load(16'h8079, 24, csum(24));
    check("match and user", {load_checksum_match, user_filter}, 2'b11);
    check("taps", tap_count_code, 4'h3);
    peek(6'h00, 27'h32B_9688);
    peek(6'h0B, 27'h404_3B5F);
    peek(6'h0C, 27'h000_0000);
    wctl(16'h0879); // status select keeps taps and decimation
    apb(1'b0, H_RX_OFF, 32'h0000_0000);
    check("status after load", rr[15:0], stat(1'b1, 1'b1, 5'h19));
    $display("test good load done");
  endtask
  task automatic t_load_bad();
    load(16'h8039, 12, csum(12) + 16'h0001);
    check("match on bad sum", load_checksum_match, 1'b0);
    peek(6'h05, 27'h02C_49C2);
    peek(6'h06, 27'h000_0000);
    $display("test bad load done");
  endtask
  // reset in mid-run: control bits, flags and slots go back to their reset state
  task automatic t_reset_mid();
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    check("decim and taps after reset", {decim_code, tap_count_code}, 7'h20);
    check("match and user after reset", {load_checksum_match, user_filter}, 2'b00);
    peek(6'h00, 27'h000_0000);
    $display("test mid reset done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_ctrl();
    t_select();
    t_load_good();
    t_load_bad();
    t_reset_mid();
    end_sim();
  end
  // watchdog: the tests need a few hundred cycles
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
endmodule // test_adc_ctrl_reg_and_coef_loader
